// ### core/rws_cfg.svh
`ifndef RWS_CFG_SVH
`define RWS_CFG_SVH
// ****************************************************************
// clock and timing
// ****************************************************************
`define RWS_CLK_KHZ 125000
`define RWS_WD_BASE_MS 16
`define RWS_WD_DEF_MS 256
`define RWS_RD1_MS 10
`define RWS_RD2_MS 2
`define RWS_RELAX_NS 1000
`define RWS_RELAX_CYC ((`RWS_RELAX_NS * 125 + 999) / 1000)
`define RWS_WD_BASE_CYC (`RWS_WD_BASE_MS * `RWS_CLK_KHZ)
`define RWS_RD1_CYC (`RWS_RD1_MS * `RWS_CLK_KHZ)
`define RWS_RD2_CYC (`RWS_RD2_MS * `RWS_CLK_KHZ)
// ****************************************************************
// watchdog fields and reset values
// ****************************************************************
`define RWS_WD_SEL_W 3
`define RWS_WD_DEF_SEL 3'h4
`define RWS_WD_SEL_MAX 3'h6
`define RWS_WD_DEF_WINDOW 1'h0
// ****************************************************************
// fallback status bit positions
// ****************************************************************
`define RWS_FB_WD 0
`define RWS_FB_CLAMP_LO 1
`define RWS_FB_CLAMP_HI 2
`endif

// ### core/rws_pkg.sv
// ****************************************************************
// supervisor types
// ****************************************************************
package rws_pkg;
  typedef enum logic [6:0] {
    M_INIT = 7'h01, M_NORMAL = 7'h02, M_STOP = 7'h04, M_FLASH = 7'h08,
    M_SLEEP = 7'h10, M_FAILSAFE = 7'h20, M_RESTART = 7'h40
  } rws_mode_t;
  typedef enum logic [2:0] {PH_HOLD = 3'h1, PH_RELAX = 3'h2, PH_RUN = 3'h4} rws_phase_t;
  typedef enum logic [1:0] {
    CAUSE_NONE = 2'h0, CAUSE_WD = 2'h1, CAUSE_PIN = 2'h2, CAUSE_UV = 2'h3
  } rws_cause_t;
endpackage

// ### core/rws_supervisor.sv
// How it works
// - reset pin is pulled low from power-up onward
// - hold reset for selected delay counted from reset entry, release once supply has also passed threshold
// - a failed watchdog service drives the reset pin low
// - undervoltage threshold and reset delay are selectable by configuration
// - reset pin failure enters fail-safe or restart and raises fallback output
// - unexpected falling edge on released pin enters restart mode
// - pin still low after delay and relaxation flags clamped-low failure
// - short-high check only while driving low in restart or init
// - outside pull-down while released forces restart with full reset delay
// - pin held low beyond the issued reset reports clamped reset
// - watchdog is window or time-out type with programmable period
// - watchdog may be disabled only in stop or software update mode
// - watchdog timer starts counting one cycle after the watchdog becomes active
// - power-up watchdog setting is time-out with 256 ms period
// - after watchdog reset, normal mode restarts with the default 256 ms time-out
// - every reset clears the stored toggle bit to 0
// - software development mode flags watchdog failure instead of resetting
// - in init the watchdog is programmable but not running
// - stop and software update keep the watchdog setup fixed
// - sleep and fail-safe turn watchdog off and drop its setup
// - restart turns watchdog off, next normal uses 256 ms time-out
// - toggle writes are accepted only when serial select returns high
// - missed trigger resets, enters configured mode, records failure status
`include "rws_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rws_supervisor
  import rws_pkg::*;
#(
  parameter int unsigned WD_BASE_CYC = `RWS_WD_BASE_CYC,
  parameter int unsigned RD1_CYC = `RWS_RD1_CYC,
  parameter int unsigned RD2_CYC = `RWS_RD2_CYC,
  parameter int unsigned RELAX_CYC = `RWS_RELAX_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // analog and pin inputs
  input wire logic i_supply_ok,
  input wire logic i_reset_pin_in,
  input wire logic i_serial_select_n,
  // serial frame contents, valid at select release
  input wire logic i_frame_wd_write,
  input wire logic i_frame_toggle_bit,
  input wire logic i_frame_cfg_write,
  input wire logic i_frame_cfg_window,
  input wire logic [2:0] i_frame_cfg_sel,
  input wire logic i_frame_wd_disable,
  input wire logic i_mode_req_valid,
  input wire rws_mode_t i_mode_req,
  // configuration and events
  input wire logic i_cfg_fail_safe,
  input wire logic i_cfg_delay_sel,
  input wire logic [1:0] i_cfg_uv_sel,
  input wire logic i_sw_dev_mode,
  input wire logic i_wake,
  input wire logic i_status_clear,
  // reset pin, open drain
  output logic o_reset_pin_out,
  output logic o_reset_pin_oe_n,
  // status
  output rws_mode_t o_mode,
  output logic o_fallback,
  output logic [1:0] o_reset_cause,
  output logic [2:0] o_fallback_status,
  output logic o_wd_fail_flag,
  output logic o_wrong_wd_set,
  output logic o_int_pulse,
  output logic o_wd_active,
  output logic o_wd_window,
  output logic [2:0] o_wd_sel,
  output logic o_toggle_bit,
  output logic [1:0] o_uv_threshold_sel
);
  if (WD_BASE_CYC < 4 || WD_BASE_CYC > 32'h01FFFFFF || RD1_CYC < 1 || RD2_CYC < 1
      || RELAX_CYC < 4) begin : g_chk
    $error("rws_supervisor: timing parameter out of range");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] wd_period(input logic [2:0] sel);
    wd_period = 32'(WD_BASE_CYC) << sel;
  endfunction
  function automatic rws_mode_t fail_target(input logic to_safe);
    fail_target = to_safe ? M_FAILSAFE : M_RESTART;
  endfunction

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [2:0] sup_s_r, pin_s_r, csn_s_r;
  logic sup_st_r, pin_st_r, csn_st_r;
  // three stages each, stable copy follows once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sup_s_r <= 3'h0;
      pin_s_r <= 3'h0;
      csn_s_r <= 3'h7;
      sup_st_r <= 1'b0;
      pin_st_r <= 1'b0;
      csn_st_r <= 1'b1;
    end else begin
      sup_s_r <= {sup_s_r[1:0], i_supply_ok};
      pin_s_r <= {pin_s_r[1:0], i_reset_pin_in};
      csn_s_r <= {csn_s_r[1:0], i_serial_select_n};
      if (sup_s_r[1] == sup_s_r[2]) sup_st_r <= sup_s_r[2];
      if (pin_s_r[1] == pin_s_r[2]) pin_st_r <= pin_s_r[2];
      if (csn_s_r[1] == csn_s_r[2]) csn_st_r <= csn_s_r[2];
    end
  end
  wire logic csn_rise = csn_s_r[1] & csn_s_r[2] & ~csn_st_r;
  wire logic pin_fall = ~pin_s_r[1] & ~pin_s_r[2] & pin_st_r;

  // ****************************************************************
  // state
  // ****************************************************************
  rws_mode_t mode_r, mode_nxt;
  rws_phase_t ph_r, ph_nxt;
  logic [31:0] cnt_r, cnt_nxt, wd_cnt_r, wd_cnt_nxt;
  logic wd_window_r, wd_off_r, wd_act_r, toggle_r, out_r;
  logic [2:0] wd_sel_r, fb_r;
  logic [1:0] cause_r, uv_r;
  logic fallback_r, wd_flag_r, wrong_r, int_r;
  logic oe_n_r;

  // ****************************************************************
  // reset pin sequencing
  // ****************************************************************
  wire logic [31:0] dly_cyc = i_cfg_delay_sel ? 32'(RD2_CYC) : 32'(RD1_CYC);
  wire logic seq_mode = (mode_r == M_INIT) | (mode_r == M_RESTART);
  wire logic off_mode = (mode_r == M_SLEEP) | (mode_r == M_FAILSAFE);
  wire logic hold_done = (ph_r == PH_HOLD) & seq_mode & sup_st_r & (cnt_r >= dly_cyc);
  wire logic relax_done = (ph_r == PH_RELAX) & (cnt_r >= 32'(RELAX_CYC));
  wire logic clamp_hi = (ph_r == PH_HOLD) & seq_mode & (cnt_r >= 32'(RELAX_CYC))
      & pin_st_r;
  wire logic clamp_lo = relax_done & ~pin_st_r;
  wire logic pin_fail = clamp_hi | clamp_lo;
  wire logic ext_pull = (ph_r == PH_RUN) & pin_fall & (mode_r != M_RESTART);
  wire logic uv_drop = (ph_r == PH_RUN) & ~sup_st_r & ~off_mode;

  // ****************************************************************
  // watchdog decode
  // ****************************************************************
  wire logic wd_act = (mode_r == M_NORMAL)
      | (((mode_r == M_STOP) | (mode_r == M_FLASH)) & ~wd_off_r);
  wire logic [31:0] wd_per = wd_period(wd_sel_r);
  wire logic [31:0] wd_half = wd_period(wd_sel_r) >> 1;
  wire logic trig_write = csn_rise & i_frame_wd_write;
  wire logic trig_tog = trig_write & (i_frame_toggle_bit != toggle_r);
  wire logic wd_early = wd_act & trig_tog & wd_window_r & (wd_cnt_r < wd_half);
  wire logic wd_late = wd_act & (wd_cnt_r >= wd_per - 32'h1);
  wire logic wd_fail = wd_early | wd_late;
  wire logic trig_ok = wd_act & trig_tog & ~wd_early;
  wire logic wd_rst = wd_fail & ~i_sw_dev_mode;
  wire logic fail_act = pin_fail | wd_rst;
  wire logic sel_ok = i_frame_cfg_sel <= `RWS_WD_SEL_MAX;
  wire logic cfg_try = csn_rise & i_frame_cfg_write;
  wire logic cfg_slot = (mode_r == M_INIT) | ((mode_r == M_NORMAL) & trig_ok);
  wire logic cfg_take = cfg_try & cfg_slot & sel_ok;
  wire logic keep_mode = (mode_r == M_STOP) | (mode_r == M_FLASH);
  wire logic dis_ok = csn_rise & i_frame_wd_disable & keep_mode;
  wire logic wrong_set = (cfg_try & ~(cfg_slot & sel_ok))
      | (csn_rise & i_frame_wd_disable & ~keep_mode);
  wire logic req_legal = (i_mode_req == M_NORMAL) | ((mode_r == M_NORMAL)
      & ((i_mode_req == M_STOP) | (i_mode_req == M_FLASH) | (i_mode_req == M_SLEEP)));
  wire logic mode_take = csn_rise & i_mode_req_valid & (ph_r == PH_RUN) & req_legal
      & (seq_mode | (mode_r == M_NORMAL) | keep_mode) & (mode_r != M_RESTART);

  // mode selection, failures first
  always_comb begin
    mode_nxt = mode_r;
    if (fail_act) begin
      mode_nxt = fail_target(i_cfg_fail_safe);
    end else if (ext_pull | uv_drop) begin
      mode_nxt = M_RESTART;
    end else begin
      case (mode_r)
        M_INIT, M_NORMAL, M_STOP, M_FLASH: begin
          if (mode_take) mode_nxt = i_mode_req;
        end
        M_SLEEP, M_FAILSAFE: begin
          if (i_wake) mode_nxt = M_RESTART;
        end
        M_RESTART: begin
          if (relax_done & pin_st_r) mode_nxt = M_NORMAL;
        end
        default: mode_nxt = M_RESTART;
      endcase
    end
  end
  wire logic to_off = (mode_nxt != mode_r) & ((mode_nxt == M_SLEEP) | (mode_nxt == M_FAILSAFE));
  wire logic go_reset = fail_act | ext_pull | uv_drop | to_off | ((mode_nxt == M_RESTART)
      & (mode_r != M_RESTART));

  // sequencing phase and its counter
  always_comb begin
    ph_nxt = ph_r;
    cnt_nxt = cnt_r + 32'h1;
    case (ph_r)
      PH_HOLD: begin
        if (hold_done) begin
          ph_nxt = PH_RELAX;
          cnt_nxt = 32'h0;
        end
      end
      PH_RELAX: begin
        if (relax_done) begin
          ph_nxt = PH_RUN;
          cnt_nxt = 32'h0;
        end
      end
      PH_RUN: cnt_nxt = 32'h0;
      default: ph_nxt = PH_HOLD;
    endcase
    if (go_reset) begin
      ph_nxt = PH_HOLD;
      cnt_nxt = 32'h0;
    end
  end

  // watchdog timer, zero when idle, restarted on activation and service
  assign wd_cnt_nxt = (~wd_act | ~wd_act_r | trig_ok | wd_fail) ? 32'h0 : wd_cnt_r + 32'h1;
  wire logic dflt = (mode_r == M_RESTART) | off_mode;
  wire logic [2:0] fb_set = {clamp_hi, clamp_lo, wd_fail};
  wire logic [1:0] cause_set = wd_rst ? CAUSE_WD : pin_fail ? CAUSE_PIN
      : uv_drop ? CAUSE_UV : ext_pull ? CAUSE_PIN : CAUSE_NONE;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_r <= M_INIT;
      ph_r <= PH_HOLD;
      cnt_r <= 32'h0;
      out_r <= 1'b0;
      oe_n_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      out_r <= 1'b0;
      oe_n_r <= (ph_nxt != PH_HOLD);
    end
  end

  // watchdog setup and timer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wd_window_r <= `RWS_WD_DEF_WINDOW;
      wd_sel_r <= `RWS_WD_DEF_SEL;
      wd_off_r <= 1'b0;
      wd_act_r <= 1'b0;
      wd_cnt_r <= 32'h0;
      toggle_r <= 1'b0;
    end else begin
      wd_act_r <= wd_act;
      wd_cnt_r <= wd_cnt_nxt;
      wd_off_r <= keep_mode & (wd_off_r | dis_ok);
      if (dflt) begin
        wd_window_r <= `RWS_WD_DEF_WINDOW;
        wd_sel_r <= `RWS_WD_DEF_SEL;
      end else if (cfg_take) begin
        wd_window_r <= i_frame_cfg_window;
        wd_sel_r <= i_frame_cfg_sel;
      end
      if (go_reset) toggle_r <= 1'b0;
      else if (trig_write) toggle_r <= i_frame_toggle_bit;
    end
  end

  // sticky status, a new event wins over a clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      fb_r <= 3'h0;
      cause_r <= CAUSE_NONE;
      fallback_r <= 1'b0;
      wd_flag_r <= 1'b0;
      wrong_r <= 1'b0;
      int_r <= 1'b0;
      uv_r <= 2'h0;
    end else begin
      fb_r <= (fb_r & {3{~i_status_clear}}) | fb_set;
      if (cause_set != CAUSE_NONE) cause_r <= cause_set;
      else if (i_status_clear) cause_r <= CAUSE_NONE;
      fallback_r <= fallback_r | fail_act;
      wd_flag_r <= (wd_flag_r & ~i_status_clear) | (wd_fail & i_sw_dev_mode);
      wrong_r <= (wrong_r & ~i_status_clear) | wrong_set;
      int_r <= (wd_fail & i_sw_dev_mode) | wrong_set;
      uv_r <= i_cfg_uv_sel;
    end
  end

  // outputs straight from flops
  assign o_reset_pin_out = out_r;
  assign o_reset_pin_oe_n = oe_n_r;
  assign o_mode = mode_r;
  assign o_fallback = fallback_r;
  assign o_reset_cause = cause_r;
  assign o_fallback_status = fb_r;
  assign o_wd_fail_flag = wd_flag_r;
  assign o_wrong_wd_set = wrong_r;
  assign o_int_pulse = int_r;
  assign o_wd_active = wd_act_r;
  assign o_wd_window = wd_window_r;
  assign o_wd_sel = wd_sel_r;
  assign o_toggle_bit = toggle_r;
  assign o_uv_threshold_sel = uv_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_por_low;
    (mode_r == M_INIT) && (ph_r == PH_HOLD) && !sup_st_r |=> !o_reset_pin_oe_n;
  endproperty
  a_por_low: assert property (p_por_low) else $error("reset not held low at power-up");
  property p_hold_delay;
    (ph_r == PH_HOLD) && !go_reset && seq_mode && (cnt_r < dly_cyc) |=> ph_r == PH_HOLD;
  endproperty
  a_hold_delay: assert property (p_hold_delay) else $error("reset released early");
  property p_wd_reset;
    wd_fail && !i_sw_dev_mode |=> !o_reset_pin_oe_n && (toggle_r == 1'b0);
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("no reset on watchdog failure");
  property p_pin_fail;
    pin_fail |=> o_fallback && (mode_r == (i_cfg_fail_safe ? M_FAILSAFE : M_RESTART)) [*1];
  endproperty
  a_pin_fail: assert property (p_pin_fail) else $error("pin failure not handled");
  property p_ext_pull;
    ext_pull && !fail_act |=> (mode_r == M_RESTART) && (ph_r == PH_HOLD) && (cnt_r == 32'h0);
  endproperty
  a_ext_pull: assert property (p_ext_pull) else $error("outside pull not restarted");
  property p_clamp_lo;
    clamp_lo |=> o_fallback_status[`RWS_FB_CLAMP_LO] ##1 o_fallback_status[`RWS_FB_CLAMP_LO]
        || $past(i_status_clear);
  endproperty
  a_clamp_lo: assert property (p_clamp_lo) else $error("clamped low not flagged");
  property p_disable;
    $rose(wd_off_r) |-> $past(keep_mode);
  endproperty
  a_disable: assert property (p_disable) else $error("watchdog disabled outside stop");
  property p_default;
    (mode_r == M_RESTART) |=> (wd_sel_r == `RWS_WD_DEF_SEL) && !wd_window_r;
  endproperty
  a_default: assert property (p_default) else $error("restart kept watchdog setup");
  property p_swdev;
    wd_fail && i_sw_dev_mode && !pin_fail |=> o_wd_fail_flag && o_int_pulse
        && (mode_r == $past(mode_nxt));
  endproperty
  a_swdev: assert property (p_swdev) else $error("development mode misses flag");
  property p_init_off;
    (mode_r == M_INIT) |-> !wd_act ##1 (wd_cnt_r == 32'h0);
  endproperty
  a_init_off: assert property (p_init_off) else $error("watchdog runs in init");
  property p_toggle_edge;
    $changed(toggle_r) && (toggle_r == 1'b1) |-> $past(csn_rise);
  endproperty
  a_toggle_edge: assert property (p_toggle_edge) else $error("toggle taken off select");
  c_restart: cover property (ext_pull ##[1:1000] (mode_r == M_NORMAL));
  c_wd_fail: cover property (wd_late && !i_sw_dev_mode);
  c_trigger: cover property (trig_ok ##[1:1000] trig_ok);
  c_clamp_hi: cover property (clamp_hi);
endmodule // rws_supervisor
`default_nettype wire

// ### verif/rws_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// reset line as seen by the controller board
// ****************************************************************
module rws_mcu_model (
  // supervisor drive
  input wire logic i_oe_n,
  // board faults commanded by the bench
  input wire logic i_pull_low,
  input wire logic i_clamp_high,
  // resolved wire level
  output logic o_level
);
  // pull-up keeps the line high when nobody pulls it down
  // a short to supply wins over every pull-down
  assign o_level = i_clamp_high ? 1'b1 :
    ((!i_oe_n) || i_pull_low) ? 1'b0 : 1'b1;
endmodule // rws_mcu_model
`default_nettype wire

// ### verif/rws_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rws_supervisor_tb_top
  import rws_pkg::*;
;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic i_clk = 0, i_rst_n = 0, i_supply_ok = 1, i_serial_select_n = 1;
  logic i_frame_wd_write = 0, i_frame_toggle_bit = 0, i_frame_cfg_write = 0;
  logic i_frame_cfg_window = 0, i_frame_wd_disable = 0, i_mode_req_valid = 0;
  logic [2:0] i_frame_cfg_sel = 3'h0;
  rws_mode_t i_mode_req = M_INIT;
  logic i_cfg_fail_safe = 0, i_cfg_delay_sel = 0, i_sw_dev_mode = 0;
  logic i_wake = 0, i_status_clear = 0, pull_low = 0, clamp_high = 0;
  logic [1:0] i_cfg_uv_sel = 2'h0;
  wire logic i_reset_pin_in;
  logic o_reset_pin_out, o_reset_pin_oe_n, o_fallback, o_wd_fail_flag, o_wrong_wd_set;
  logic o_int_pulse, o_wd_active, o_wd_window, o_toggle_bit;
  logic [1:0] o_reset_cause, o_uv_threshold_sel;
  logic [2:0] o_fallback_status, o_wd_sel;
  rws_mode_t o_mode;
  int n_errors = 0, n_compared = 0, n;
  // short counts keep the run brief
  rws_supervisor #(.WD_BASE_CYC(16), .RD1_CYC(40), .RD2_CYC(20), .RELAX_CYC(8)) DUT (
    .i_clk, .i_rst_n, .i_supply_ok, .i_reset_pin_in, .i_serial_select_n,
    .i_frame_wd_write, .i_frame_toggle_bit, .i_frame_cfg_write, .i_frame_cfg_window,
    .i_frame_cfg_sel, .i_frame_wd_disable, .i_mode_req_valid, .i_mode_req,
    .i_cfg_fail_safe, .i_cfg_delay_sel, .i_cfg_uv_sel, .i_sw_dev_mode, .i_wake,
    .i_status_clear, .o_reset_pin_out, .o_reset_pin_oe_n, .o_mode, .o_fallback,
    .o_reset_cause, .o_fallback_status, .o_wd_fail_flag, .o_wrong_wd_set, .o_int_pulse,
    .o_wd_active, .o_wd_window, .o_wd_sel, .o_toggle_bit, .o_uv_threshold_sel);
  rws_mcu_model u_line (.i_oe_n(o_reset_pin_oe_n), .i_pull_low(pull_low),
    .i_clamp_high(clamp_high), .o_level(i_reset_pin_in));
  // free running clock
  always #4 i_clk = ~i_clk;
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one serial frame, fields held well past the select rise
  task automatic frame(input logic wr, tg, cw, win, input logic [2:0] sel,
                       input logic dis, mv, input rws_mode_t m);
    @(posedge i_clk);
    i_frame_wd_write <= wr;
    i_frame_toggle_bit <= tg;
    i_frame_cfg_write <= cw;
    i_frame_cfg_window <= win;
    i_frame_cfg_sel <= sel;
    i_frame_wd_disable <= dis;
    i_mode_req_valid <= mv;
    i_mode_req <= m;
    i_serial_select_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_serial_select_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_frame_wd_write <= 1'b0;
    i_frame_cfg_write <= 1'b0;
    i_frame_wd_disable <= 1'b0;
    i_mode_req_valid <= 1'b0;
    #1;
  endtask
  task automatic wait_mode(input rws_mode_t m, input int lim);
    for (n = 0; n < lim && o_mode !== m; n++) begin
      @(posedge i_clk);
      #1;
    end
    #1;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_power_up();
    repeat (12) @(posedge i_clk);
    #1;
    chk(o_reset_pin_oe_n, 0);
    chk(o_mode, M_INIT);
    chk(o_wd_sel, 3'h4);
    chk(o_wd_window, 0);
    chk(o_toggle_bit, 0);
    chk(o_reset_pin_out, 0);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    i_cfg_uv_sel <= 2'h2;
    for (n = 0; n < 100 && o_reset_pin_oe_n !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    #1;
    chk(8'(n >= 40 && n <= 52), 1);
    repeat (12) @(posedge i_clk);
  endtask
  task automatic t_init_setup();
    frame(0, 0, 1, 0, 3'h7, 0, 0, M_INIT);
    chk(o_wrong_wd_set, 1);
    chk(o_wd_sel, 3'h4);
    frame(0, 0, 1, 0, 3'h1, 0, 0, M_INIT);
    chk(o_wd_sel, 3'h1);
    chk(o_wd_active, 0);
    chk(o_uv_threshold_sel, 2'h2);
    frame(0, 0, 0, 0, 3'h0, 0, 1, M_NORMAL);
    chk(o_mode, M_NORMAL);
    chk(o_wd_active, 1);
    frame(1, 1, 0, 0, 3'h0, 0, 0, M_INIT);
    chk(o_toggle_bit, 1);
    frame(1, 0, 0, 0, 3'h0, 0, 0, M_INIT);
    chk(o_toggle_bit, 0);
  endtask
  task automatic t_wd_fail();
    for (n = 0; n < 60 && o_reset_pin_oe_n !== 1'b0; n++) begin
      @(posedge i_clk);
      #1;
    end
    #1;
    chk(8'(n >= 16), 1);
    chk(o_reset_pin_oe_n, 0);
    chk(o_mode, M_RESTART);
    chk(o_reset_cause, CAUSE_WD);
    chk(o_fallback_status[0], 1);
    chk(o_toggle_bit, 0);
    wait_mode(M_NORMAL, 100);
    chk(o_mode, M_NORMAL);
    chk(o_wd_sel, 3'h4);
    chk(o_wd_window, 0);
    @(posedge i_clk);
    #1;
    chk(o_wd_active, 1);
  endtask
  task automatic t_dev_mode();
    @(posedge i_clk);
    i_sw_dev_mode <= 1'b1;
    for (n = 0; n < 300 && o_wd_fail_flag !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    chk(o_wd_fail_flag, 1);
    chk(o_int_pulse, 1);
    chk(o_reset_pin_oe_n, 1);
    chk(o_mode, M_NORMAL);
    @(posedge i_clk);
    i_sw_dev_mode <= 1'b0;
    i_status_clear <= 1'b1;
    @(posedge i_clk);
    i_status_clear <= 1'b0;
    frame(1, 1, 0, 0, 3'h0, 0, 0, M_INIT);
    chk(o_wrong_wd_set, 0);
  endtask
  task automatic t_stop();
    frame(0, 0, 0, 0, 3'h0, 1, 0, M_INIT);
    chk(o_wrong_wd_set, 1);
    chk(o_wd_active, 1);
    frame(0, 0, 0, 0, 3'h0, 0, 1, M_STOP);
    frame(0, 0, 0, 0, 3'h0, 1, 0, M_INIT);
    chk(o_wd_active, 0);
    frame(0, 0, 1, 0, 3'h2, 0, 0, M_INIT);
    chk(o_wd_sel, 3'h4);
    repeat (300) @(posedge i_clk);
    #1;
    chk(o_mode, M_STOP);
    chk(o_reset_pin_oe_n, 1);
  endtask
  task automatic t_outside_pull();
    @(posedge i_clk);
    pull_low <= 1'b1;
    wait_mode(M_RESTART, 20);
    chk(o_mode, M_RESTART);
    @(posedge i_clk);
    pull_low <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    chk(o_reset_pin_oe_n, 0);
    chk(o_reset_cause, CAUSE_PIN);
    wait_mode(M_NORMAL, 100);
    chk(o_mode, M_NORMAL);
  endtask
  task automatic t_clamps();
    @(posedge i_clk);
    i_cfg_fail_safe <= 1'b1;
    i_cfg_delay_sel <= 1'b1;
    pull_low <= 1'b1;
    wait_mode(M_FAILSAFE, 150);
    chk(o_mode, M_FAILSAFE);
    chk(o_fallback_status[1], 1);
    chk(o_fallback, 1);
    chk(o_reset_cause, CAUSE_PIN);
    chk(o_wd_active, 0);
    @(posedge i_clk);
    pull_low <= 1'b0;
    clamp_high <= 1'b1;
    i_wake <= 1'b1;
    @(posedge i_clk);
    i_wake <= 1'b0;
    for (n = 0; n < 100 && o_fallback_status[2] !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    #1;
    chk(o_fallback_status[2], 1);
  endtask
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    t_power_up();
    t_init_setup();
    t_wd_fail();
    t_dev_mode();
    t_stop();
    t_outside_pull();
    t_clamps();
    report_and_stop();
  end
  // cuts a hang short well beyond the expected run length
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule // rws_supervisor_tb_top
`default_nettype wire
